// [cdio_banks.sv]
// Behaviour
// - Input bank always accessible; wait while used register moves to kernel after start.
// - With increment control set, an input write increments the register instead.
// - Input bank supports XOR-write mode.
// - Writes during busy proceed but stall until used register reached the kernel.
// - Start-update mode: input writes during result refresh raise wait.
// - Wait rises on conflicting access, falls first edge after transfer ends.
// - Flush control fills input bank and result bank with random data.
// - Input bank index beyond configured count accesses bank zero, no alert.
// - Start-update mode: result bank readable any time, possibly with wait.
// - End-update mode: result access while busy raises security alert error.
// - Result register runs on the engine core clock.
// - Result stores kernel output, or kernel output XOR an input register.
// - Update-select sampled at start: 00 end, 01 start, 10 trigger, 11 none.
// - Start-update loads result from last-used kernel first; reset picks first kernel.
// - Result access during start-update refresh raises wait; master stalls.
// - End-update mode loads kernel result when the operation finishes.
// - Update-select 10 copies working register to result, busy held, no cipher.
// - Start while busy is ignored.
// - Trigger-update ignores operation select, uses remembered last operation.
// - Update-select 11 runs operation, result bank left unchanged.
// - Result contents after first trigger or start update are undefined.
// - Special write priority: flush-write, then XOR-write, then increment.
// - XOR-write stores written data XOR current register contents.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "cdio_params.svh"

module cdio_banks (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Kernel side
    input wire logic [127:0] kern_work_i,
    input wire logic kern_done_i,
    input wire logic [31:0] rnd_i,
    output logic [1:0] kern_sel_o,
    output logic kern_load_o,
    output logic [1:0] kern_widx_o,
    output logic [31:0] kern_word_o,
    output logic kern_start_o,
    // Status
    output logic busy_o,
    output logic wait_o,
    output logic alert_o
);

    // ------------------------------------------------------------
    // Storage and control state
    // ------------------------------------------------------------
    // Banks carry no reset; flush is the way to scrub them
    logic [31:0] in_bank [16];
    logic [31:0] res_bank [4];
    cdio_pkg::cdio_state_e st;
    cdio_pkg::cdio_upd_e upd_sel;
    cdio_pkg::cdio_upd_e mode_q;
    logic xor_sel;
    logic [1:0] src_sel;
    logic [1:0] op_sel;
    logic incr_en;
    logic xorwr_en;
    logic flush_write_mode_en;
    logic xor_q;
    logic [1:0] src_q;
    logic [1:0] op_q;
    logic [1:0] last_op;
    logic [1:0] cnt;
    logic flushing;
    logic [4:0] fl_cnt;
    logic ack_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic access;
    logic in_hit;
    logic res_hit;
    logic ctrl_hit;
    logic ctrl2_hit;
    logic stat_hit;
    logic [1:0] bank_req;
    logic [3:0] in_idx;
    logic stall;
    logic err;
    logic wr_fire;
    logic start_req;
    logic busy;

    assign access = psel_i & penable_i;
    assign in_hit = paddr_i[7:6] == `CDIO_IN_SEG;
    assign res_hit = paddr_i[7:4] == `CDIO_RES_SEG;
    assign ctrl_hit = paddr_i == `CDIO_OFS_CTRL;
    assign ctrl2_hit = paddr_i == `CDIO_OFS_CTRL2;
    assign stat_hit = paddr_i == `CDIO_OFS_STATUS;
    // Missing banks fold onto bank zero; folded addresses raise no error or alert
    assign bank_req = (paddr_i[5:4] >= `CDIO_NUM_IN) ? 2'h0 : paddr_i[5:4];
    assign in_idx = {bank_req, paddr_i[3:2]};
    assign busy = st != cdio_pkg::CDIO_IDLE;

    // Wait terms: single-ported banks cannot serve bus and kernel together
    always_comb begin
        stall = 1'b0;
        if (access && in_hit) begin
            if ((st == cdio_pkg::CDIO_XFER || st == cdio_pkg::CDIO_REFRESH)
                && bank_req == src_q) begin
                stall = 1'b1;
            end
            if (st == cdio_pkg::CDIO_REFRESH && pwrite_i) begin
                stall = 1'b1;
            end
        end
        if (access && res_hit
            && (st == cdio_pkg::CDIO_REFRESH || st == cdio_pkg::CDIO_TRIG)) begin
            stall = 1'b1;
        end
    end

    // Error answer: unmapped, or result access mid-operation in end-update
    always_comb begin
        err = ~(in_hit | res_hit | ctrl_hit | ctrl2_hit | stat_hit);
        if (res_hit && busy && mode_q == cdio_pkg::CDIO_END_UP) begin
            err = 1'b1;
        end
    end

    // The write commits at the edge where pready is sampled high
    assign wr_fire = access & ack_q & pwrite_i;
    assign start_req = wr_fire & ctrl_hit & pwdata_i[`CDIO_CTRL_START];

    // ------------------------------------------------------------
    // APB answer: one registered cycle, held back while stalled
    // ------------------------------------------------------------
    // Read data is captured with the acknowledge so it comes from a flop
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            prdata_o <= 32'h0;
            pslverr_o <= 1'b0;
            alert_o <= 1'b0;
        end else begin
            alert_o <= 1'b0;
            if (access && !ack_q && !stall) begin
                ack_q <= 1'b1;
                pslverr_o <= err;
                alert_o <= err & res_hit;
                prdata_o <= 32'h0;
                if (pwrite_i || err) begin
                    prdata_o <= 32'h0;
                end else if (in_hit) begin
                    prdata_o <= in_bank[in_idx];
                end else if (res_hit) begin
                    prdata_o <= res_bank[paddr_i[3:2]];
                end else if (ctrl_hit) begin
                    prdata_o <= {24'h0, op_sel, src_sel, xor_sel, upd_sel, 1'b0};
                end else if (ctrl2_hit) begin
                    prdata_o <= {29'h0, flush_write_mode_en, xorwr_en, incr_en};
                end else begin
                    prdata_o <= {26'h0, flushing, last_op, mode_q, busy};
                end
            end else begin
                ack_q <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    assign pready_o = ack_q;
    assign wait_o = stall;
    assign busy_o = busy;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            upd_sel <= cdio_pkg::CDIO_END_UP;
            xor_sel <= 1'b0;
            src_sel <= 2'h0;
            op_sel <= `CDIO_OP_RESET;
            incr_en <= 1'b0;
            xorwr_en <= 1'b0;
            flush_write_mode_en <= 1'b0;
        end else if (wr_fire && ctrl_hit) begin
            upd_sel <= cdio_pkg::cdio_upd_e'(pwdata_i[`CDIO_CTRL_UPD_LSB +: 2]);
            xor_sel <= pwdata_i[`CDIO_CTRL_XOR];
            src_sel <= pwdata_i[`CDIO_CTRL_SRC_LSB +: 2];
            op_sel <= pwdata_i[`CDIO_CTRL_OP_LSB +: 2];
        end else if (wr_fire && ctrl2_hit) begin
            incr_en <= pwdata_i[`CDIO_CTRL2_INCR];
            xorwr_en <= pwdata_i[`CDIO_CTRL2_XORWR];
            flush_write_mode_en <= pwdata_i[`CDIO_CTRL2_FLUSH_WRITE_MODE];
        end
    end

    // Flush sweep: one word per cycle, input bank then result bank
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            flushing <= 1'b0;
            fl_cnt <= 5'h0;
        end else if (wr_fire && ctrl2_hit && pwdata_i[`CDIO_CTRL2_FLUSH]) begin
            flushing <= 1'b1;
            fl_cnt <= 5'h0;
        end else if (flushing) begin
            fl_cnt <= fl_cnt + 5'h1;
            if (fl_cnt == `CDIO_FLUSH_LAST) begin
                flushing <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------
    // Start is only seen in idle, so a trigger never copies half-done state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st <= cdio_pkg::CDIO_IDLE;
            mode_q <= cdio_pkg::CDIO_END_UP;
            xor_q <= 1'b0;
            src_q <= 2'h0;
            op_q <= `CDIO_OP_RESET;
            last_op <= `CDIO_OP_RESET;
            kern_sel_o <= `CDIO_OP_RESET;
            cnt <= 2'h0;
            kern_start_o <= 1'b0;
        end else begin
            kern_start_o <= 1'b0;
            case (st)
                cdio_pkg::CDIO_IDLE: begin
                    cnt <= 2'h0;
                    if (start_req) begin
                        mode_q <= cdio_pkg::cdio_upd_e'(pwdata_i[`CDIO_CTRL_UPD_LSB +: 2]);
                        xor_q <= pwdata_i[`CDIO_CTRL_XOR];
                        src_q <= (pwdata_i[`CDIO_CTRL_SRC_LSB +: 2] >= `CDIO_NUM_IN) ?
                            2'h0 : pwdata_i[`CDIO_CTRL_SRC_LSB +: 2];
                        op_q <= pwdata_i[`CDIO_CTRL_OP_LSB +: 2];
                        case (pwdata_i[`CDIO_CTRL_UPD_LSB +: 2])
                            cdio_pkg::CDIO_TRIG_UP: begin
                                kern_sel_o <= last_op;
                                st <= cdio_pkg::CDIO_TRIG;
                            end
                            cdio_pkg::CDIO_START_UP: begin
                                kern_sel_o <= last_op;
                                st <= cdio_pkg::CDIO_REFRESH;
                            end
                            default: begin
                                kern_sel_o <= pwdata_i[`CDIO_CTRL_OP_LSB +: 2];
                                st <= cdio_pkg::CDIO_XFER;
                            end
                        endcase
                    end
                end
                cdio_pkg::CDIO_REFRESH: begin
                    cnt <= cnt + 2'h1;
                    if (cnt == `CDIO_LAST_WORD) begin
                        kern_sel_o <= op_q;
                        st <= cdio_pkg::CDIO_XFER;
                    end
                end
                cdio_pkg::CDIO_XFER: begin
                    cnt <= cnt + 2'h1;
                    if (cnt == `CDIO_LAST_WORD) begin
                        last_op <= op_q;
                        kern_start_o <= 1'b1;
                        st <= cdio_pkg::CDIO_RUN;
                    end
                end
                cdio_pkg::CDIO_RUN: begin
                    cnt <= 2'h0;
                    if (kern_done_i) begin
                        if (mode_q == cdio_pkg::CDIO_END_UP) begin
                            st <= cdio_pkg::CDIO_FINAL;
                        end else begin
                            st <= cdio_pkg::CDIO_IDLE;
                        end
                    end
                end
                cdio_pkg::CDIO_FINAL, cdio_pkg::CDIO_TRIG: begin
                    cnt <= cnt + 2'h1;
                    if (cnt == `CDIO_LAST_WORD) begin
                        st <= cdio_pkg::CDIO_IDLE;
                    end
                end
                default: begin
                    st <= cdio_pkg::CDIO_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Kernel feed: used input bank, one word per cycle
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            kern_load_o <= 1'b0;
            kern_widx_o <= 2'h0;
            kern_word_o <= 32'h0;
        end else begin
            kern_load_o <= st == cdio_pkg::CDIO_XFER;
            kern_widx_o <= cnt;
            kern_word_o <= in_bank[{src_q, cnt}];
        end
    end

    // ------------------------------------------------------------
    // Input bank write path
    // ------------------------------------------------------------
    logic [31:0] bmask;
    logic [31:0] cur_word;
    logic [31:0] new_word;

    assign cur_word = in_bank[in_idx];

    // One special mode at a time, flush-write outranking the others
    always_comb begin
        new_word = pwdata_i;
        if (flush_write_mode_en) begin
            new_word = rnd_i;
        end else if (xorwr_en) begin
            new_word = pwdata_i ^ cur_word;
        end else if (incr_en) begin
            new_word = cur_word + 32'h1;
        end
    end

    // Byte strobes; increment and flush-write act on the whole word
    generate
        for (genvar b = 0; b < 4; b++) begin : g_mask
            assign bmask[b*8 +: 8] = (pstrb_i[b] || flush_write_mode_en ||
                (incr_en && !xorwr_en)) ? 8'hff : 8'h00;
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (flushing && fl_cnt < `CDIO_RES_FIRST) begin
            in_bank[fl_cnt[3:0]] <= rnd_i;
        end else if (wr_fire && in_hit) begin
            in_bank[in_idx] <= (cur_word & ~bmask) | (new_word & bmask);
        end
    end

    // ------------------------------------------------------------
    // Result bank, on the core clock
    // ------------------------------------------------------------
    logic res_copy;
    logic [31:0] res_word;

    // Refresh, end-of-operation and trigger all copy the working register
    assign res_copy = st == cdio_pkg::CDIO_REFRESH || st == cdio_pkg::CDIO_FINAL
        || st == cdio_pkg::CDIO_TRIG;
    assign res_word = kern_work_i[cnt*32 +: 32] ^
        (xor_q ? in_bank[{src_q, cnt}] : 32'h0);

    always_ff @(posedge sys_clk_i) begin
        if (flushing && fl_cnt >= `CDIO_RES_FIRST) begin
            res_bank[fl_cnt[1:0]] <= rnd_i;
        end else if (res_copy) begin
            res_bank[cnt] <= res_word;
        end
    end

endmodule

// [cdio_banks_chk.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checks of the data banks
// ------------------------------------------------------------
module cdio_banks_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Bus and kernel side
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic [1:0] kern_widx_o,
    input wire logic kern_load_o,
    input wire logic kern_start_o,
    input wire logic busy_o,
    input wire logic wait_o,
    input wire logic alert_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Answer is one pulse, a cycle after an access phase that was not stalled
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i && !wait_o))
        else $error("ready without a free access cycle");
    chk_wait_holds: assert property (wait_o && psel_i && penable_i |=> !pready_o)
        else $error("ready while stalled");
    chk_wait_release: assert property ($fell(wait_o) && psel_i && penable_i |=> pready_o)
        else $error("no answer after stall release");
    // Stalls only come from transfer, refresh and trigger states, which happen while busy
    chk_wait_busy: assert property (wait_o |-> busy_o)
        else $error("wait outside busy");
    chk_alert_pulse: assert property (alert_o |-> $past(busy_o) ##1 !alert_o)
        else $error("alert outside busy or too long");
    // Feeding is four words in order, never while idle
    chk_load_burst: assert property ($rose(kern_load_o) |->
        kern_widx_o == 2'h0 ##0 kern_load_o[*4] ##0 kern_widx_o == 2'h3)
        else $error("kernel feed not four ordered words");
    chk_start_busy: assert property (kern_start_o |-> busy_o ##1 !kern_start_o)
        else $error("kernel start outside busy");
    chk_idle_quiet: assert property (!busy_o |-> !kern_load_o && !kern_start_o)
        else $error("kernel activity while idle");

    cover property (wait_o);
    cover property (alert_o);
    cover property (kern_start_o);
endmodule

bind cdio_banks cdio_banks_chk u_chk (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pready_o,
    .kern_widx_o, .kern_load_o, .kern_start_o, .busy_o, .wait_o, .alert_o);

// [cdio_kern_model.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// Kernel model: takes fed words, answers after LAT cycles
// ------------------------------------------------------------
module cdio_kern_model #(
    parameter int LAT = 20
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // From the banks
    input wire logic kern_load_i,
    input wire logic [1:0] kern_widx_i,
    input wire logic [31:0] kern_word_i,
    input wire logic kern_start_i,
    // To the banks
    output logic [127:0] kern_work_o,
    output logic kern_done_o,
    output logic [31:0] rnd_o
);
    logic [127:0] fed;
    int cnt;

    // Keep each fed word
    always_ff @(posedge sys_clk_i) begin
        if (kern_load_i) begin
            fed[32 * kern_widx_i +: 32] <= kern_word_i;
        end
    end

    // Working register moves only at done, so a refresh sees the last result
    always_ff @(posedge sys_clk_i) begin
        kern_done_o <= 1'b0;
        if (rst_i) begin
            cnt <= 0;
            kern_work_o <= '0;
        end else if (kern_start_i) begin
            cnt <= LAT;
        end else if (cnt == 1) begin
            cnt <= 0;
            kern_done_o <= 1'b1;
            kern_work_o <= fed ^ {4{32'h5a5a5a5a}};
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end

    // Random source changes every cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rnd_o <= 32'h00000001;
        end else begin
            rnd_o <= {rnd_o[30:0], rnd_o[31] ^ rnd_o[21] ^ rnd_o[1]};
        end
    end
endmodule

// [cdio_params.svh]
`ifndef CDIO_PARAMS_SVH
`define CDIO_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define CDIO_OFS_CTRL 8'h00
`define CDIO_OFS_CTRL2 8'h04
`define CDIO_OFS_STATUS 8'h08
// Input bank window 0x40..0x7c: addr[7:6] == 2'b01
`define CDIO_IN_SEG 2'h1
// Result bank window 0x80..0x8c: addr[7:4] == 4'h8
`define CDIO_RES_SEG 4'h8

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CDIO_CTRL_START 0
`define CDIO_CTRL_UPD_LSB 1
`define CDIO_CTRL_XOR 3
`define CDIO_CTRL_SRC_LSB 4
`define CDIO_CTRL_OP_LSB 6
`define CDIO_CTRL2_INCR 0
`define CDIO_CTRL2_XORWR 1
`define CDIO_CTRL2_FLUSH_WRITE_MODE 2
`define CDIO_CTRL2_FLUSH 3
`define CDIO_ST_BUSY 0
`define CDIO_ST_MODE_LSB 1
`define CDIO_ST_LAST_LSB 3
`define CDIO_ST_FLUSHING 5

// ----------------------------------------------------------------
// Sizes, counts and reset values
// ----------------------------------------------------------------
`define CDIO_NUM_IN 2'h3
`define CDIO_LAST_WORD 2'h3
`define CDIO_FLUSH_LAST 5'h13
`define CDIO_RES_FIRST 5'h10
`define CDIO_OP_RESET 2'h0

`endif

// [cdio_pkg.sv]
package cdio_pkg;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        CDIO_IDLE    = 6'h01,
        CDIO_REFRESH = 6'h02,
        CDIO_XFER    = 6'h04,
        CDIO_RUN     = 6'h08,
        CDIO_FINAL   = 6'h10,
        CDIO_TRIG    = 6'h20
    } cdio_state_e;

    // Result update policy, sampled at start
    typedef enum logic [1:0] {
        CDIO_END_UP   = 2'h0,
        CDIO_START_UP = 2'h1,
        CDIO_TRIG_UP  = 2'h2,
        CDIO_NO_UP    = 2'h3
    } cdio_upd_e;

endpackage

// [crypto_data_in_out_banks_tb.sv]
`timescale 1ns/10ps
module crypto_data_in_out_banks_tb;
    localparam logic [31:0] K = 32'h5a5a5a5a;
    localparam logic [31:0] D = 32'h10000000;
    localparam logic [31:0] N = 32'h100000ff;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rnd, kword, rd;
    logic [127:0] work;
    logic [1:0] ksel, kwidx;
    logic pready, pslverr, done, kload, kstart, busy, wt, alert, er;
    logic saw_wait = 1'b0;
    logic saw_res_wait = 1'b0;
    logic saw_alert = 1'b0;
    int failures = 0;
    int n_checks = 0;

    // Clock
    always #5 clk = ~clk;

    cdio_banks dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .kern_work_i(work),
        .kern_done_i(done), .rnd_i(rnd), .kern_sel_o(ksel), .kern_load_o(kload),
        .kern_widx_o(kwidx), .kern_word_o(kword), .kern_start_o(kstart), .busy_o(busy),
        .wait_o(wt), .alert_o(alert));

    cdio_kern_model #(.LAT(20)) u_kern (.sys_clk_i(clk), .rst_i(rst), .kern_load_i(kload),
        .kern_widx_i(kwidx), .kern_word_i(kword), .kern_start_i(kstart),
        .kern_work_o(work), .kern_done_o(done), .rnd_o(rnd));

    // Remember stalls (any, and on the result window) and alerts
    always @(posedge clk) begin
        if (wt === 1'b1) begin
            saw_wait <= 1'b1;
        end
        if (wt === 1'b1 && paddr[7] === 1'b1) begin
            saw_res_wait <= 1'b1;
        end
        if (alert === 1'b1) begin
            saw_alert <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Request held until ready, so a stall never completes it early
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 300);
        if (n >= 300) begin
            chk(0, 1, "bus timeout");
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdw(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask

    task automatic fill(input logic [31:0] base);
        for (int w = 0; w < 4; w++) begin
            wr(8'h40 + 8'(w * 4), base + w);
        end
    endtask

    task automatic till_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n >= 500) begin
            chk(0, 1, "busy timeout");
            close_out();
        end
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Banks power up unknown, so flush first
        wr(8'h04, 32'h8);
        repeat (25) @(posedge clk);
        apb(1'b0, 8'h4c, 32'h0);
        chk({31'h0, $isunknown(rd)}, 0, "input not flushed");
        apb(1'b0, 8'h8c, 32'h0);
        chk({31'h0, $isunknown(rd)}, 0, "result not flushed");
        fill(D);
        for (int w = 0; w < 4; w++) begin
            rdw(8'h70 + 8'(w * 4), D + w, "bank fold");
        end
        // Special write modes, alone and together
        wr(8'h04, 32'h2);
        wr(8'h44, K);
        rdw(8'h44, K ^ (D + 1), "xor write");
        wr(8'h04, 32'h1);
        wr(8'h48, K);
        rdw(8'h48, D + 3, "increment");
        wr(8'h04, 32'h3);
        wr(8'h4c, K);
        rdw(8'h4c, K ^ (D + 3), "xor over increment");
        wr(8'h04, 32'h6);
        wr(8'h40, K);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, rd === (K ^ D)}, 0, "flush-write lost");
        wr(8'h04, 32'h0);
        fill(D);
        // End update: result refused while busy, loaded at the end
        chk({31'h0, saw_alert}, 0, "alert before end update");
        wr(8'h00, 32'h1);
        apb(1'b0, 8'h80, 32'h0);
        chk({31'h0, er}, 1, "result access while busy");
        chk({31'h0, saw_alert}, 1, "no alert on busy result access");
        till_idle();
        for (int w = 0; w < 4; w++) begin
            rdw(8'h80 + 8'(w * 4), (D + w) ^ K, "end update");
        end
        // No update leaves the result alone
        wr(8'h40, N);
        wr(8'h00, 32'h7);
        till_idle();
        rdw(8'h80, D ^ K, "no update");
        // Start update: a write to the fed bank right after start must stall
        wr(8'h44, K ^ 32'hf0);
        wr(8'h00, 32'h3);
        wr(8'h40, 32'h0);
        chk({31'h0, saw_wait}, 1, "no input stall seen");
        rdw(8'h80, N ^ K, "refresh read");
        wr(8'h00, 32'h5);
        till_idle();
        repeat (3) @(posedge clk);
        chk({31'h0, busy}, 0, "start while busy taken");
        // Second refresh: the read stalls, then shows the first run was fed N
        wr(8'h00, 32'h3);
        rdw(8'h80, N ^ K, "input overwritten");
        chk({31'h0, saw_res_wait}, 1, "no result stall seen");
        till_idle();
        // Trigger update with a foreign operation select
        wr(8'h00, 32'hc5);
        chk({30'h0, ksel}, 0, "trigger source");
        till_idle();
        rdw(8'h80, K, "trigger word zero");
        rdw(8'h84, 32'hf0, "trigger copy");
        // Result mixed with the source bank cancels the fed data, leaving the kernel mask
        wr(8'h00, 32'h9);
        till_idle();
        rdw(8'h88, K, "xor select");
        close_out();
    end
endmodule
